// ===== design/fu_cfg.svh
// Contract
// [RULE1] unlock key register is write-only, reads zero
// [RULE2] key writes only open the start gate
// [RULE3] target address is 32-bit read/write, resets zero
// [RULE4] page erase ignores address bits 11:0
// [RULE5] row program ignores address bits 8:0
// [RULE6] word program ignores address bits 1:0
// [RULE7] quad-word program ignores address bits 3:0
// [RULE8] other operation codes never use the address
// [RULE9] address cleared by power-on reset only
// [RULE10] keys are parameters; bad sequence rejects start
`ifndef FU_CFG_SVH
`define FU_CFG_SVH

// register offsets on the local register port
`define FU_OFF_KEY 4'h0
`define FU_OFF_ADDR 4'h4
`define FU_OFF_CTL 4'h8

// operation control register field positions
`define FU_CTL_OP_LSB 0
`define FU_CTL_OP_MSB 3
`define FU_CTL_BUSY_BIT 4
`define FU_CTL_UNLK_BIT 5
`define FU_CTL_ERR_BIT 6
`define FU_CTL_GO_BIT 7

// reset values
`define FU_ADDR_RST 32'h0000_0000
`define FU_ZERO_WORD 32'h0000_0000

// number of low address bits dropped per operation
`define FU_PAGE_IGN 12
`define FU_ROW_IGN 9
`define FU_WORD_IGN 2
`define FU_QUAD_IGN 4

// operation select encodings
`define FU_OPC_NOP 4'h0
`define FU_OPC_WORD 4'h1
`define FU_OPC_QUAD 4'h2
`define FU_OPC_ROW 4'h3
`define FU_OPC_PAGE 4'h4

// default unlock keys, arbitrary values
`define FU_KEY_FIRST_DFLT 32'h1234_5678
`define FU_KEY_SECOND_DFLT 32'h8765_4321

`endif

// ===== design/fu_pkg.sv
package fu_pkg;
`include "fu_cfg.svh"

  typedef enum logic [3:0] {
    FU_OP_NOP = `FU_OPC_NOP,
    FU_OP_WORD = `FU_OPC_WORD,
    FU_OP_QUAD = `FU_OPC_QUAD,
    FU_OP_ROW = `FU_OPC_ROW,
    FU_OP_PAGE = `FU_OPC_PAGE
  } fu_op_t;

  typedef enum logic [1:0] {
    FU_KS_IDLE = 2'b00,
    FU_KS_FIRST = 2'b01,
    FU_KS_OPEN = 2'b10
  } fu_key_st_t;

  typedef struct packed {
    fu_key_st_t st;
  } fu_key_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] op;
    logic busy;
    logic err;
    logic go;
    logic [3:0] go_op;
    logic [31:0] go_addr;
    logic go_used;
    logic [31:0] rdata;
  } fu_regs_state_t;

  // operations that read the target address at all
  function automatic logic fu_op_uses_addr(input logic [3:0] op);
    fu_op_uses_addr = (op == FU_OP_PAGE) || (op == FU_OP_ROW) ||
                      (op == FU_OP_WORD) || (op == FU_OP_QUAD);
  endfunction

  // mask of the low address bits that the operation disregards
  function automatic logic [31:0] fu_ign_mask(input logic [3:0] op);
    logic [31:0] one;
    one = 32'h0000_0001;
    case (op)
      FU_OP_PAGE: fu_ign_mask = (one << `FU_PAGE_IGN) - one;
      FU_OP_ROW: fu_ign_mask = (one << `FU_ROW_IGN) - one;
      FU_OP_WORD: fu_ign_mask = (one << `FU_WORD_IGN) - one;
      FU_OP_QUAD: fu_ign_mask = (one << `FU_QUAD_IGN) - one;
      default: fu_ign_mask = 32'hffff_ffff;
    endcase
  endfunction

endpackage

// ===== design/fu_keychk.sv
`timescale 1ns/100ps
`include "fu_cfg.svh"
module fu_keychk #(
  parameter logic [31:0] KEY_FIRST = `FU_KEY_FIRST_DFLT,
  parameter logic [31:0] KEY_SECOND = `FU_KEY_SECOND_DFLT
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  // key writes and start attempts
  input wire logic key_wr,
  input wire logic [31:0] key_data,
  input wire logic consume,
  // gate state
  output logic unlocked
);
  import fu_pkg::*;

  fu_key_state_t cur_ff;
  fu_key_state_t nxt_ff;

  always_comb begin
    nxt_ff = cur_ff;
    if (soft_rst) begin
      nxt_ff.st = FU_KS_IDLE;
    end else if (key_wr) begin
      // any wrong value drops back; a first key restarts the pair, except straight after a first key, where it drops back too
      case (cur_ff.st)
        FU_KS_IDLE: nxt_ff.st = (key_data == KEY_FIRST) ? FU_KS_FIRST : FU_KS_IDLE; // RULE10
        FU_KS_FIRST: nxt_ff.st = (key_data == KEY_SECOND) ? FU_KS_OPEN : FU_KS_IDLE; // RULE10
        FU_KS_OPEN: nxt_ff.st = (key_data == KEY_FIRST) ? FU_KS_FIRST : FU_KS_IDLE; // RULE10
        default: nxt_ff.st = FU_KS_IDLE;
      endcase
    end else if (consume) begin
      // one opening allows exactly one start attempt
      nxt_ff.st = FU_KS_IDLE; // RULE2
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '{st: FU_KS_IDLE};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign unlocked = (cur_ff.st == FU_KS_OPEN);

  key_pair_open_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE10
    (key_wr && !soft_rst && key_data == KEY_SECOND && cur_ff.st == FU_KS_FIRST) |=> unlocked)
    else $error("second key after first key did not open the gate");

endmodule

// ===== design/fu_regs.sv
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "fu_cfg.svh"
module fu_regs #(
  parameter logic [31:0] KEY_FIRST = `FU_KEY_FIRST_DFLT,
  parameter logic [31:0] KEY_SECOND = `FU_KEY_SECOND_DFLT
) (
  // clock and power-on reset
  input wire logic core_clk,
  input wire logic rst_n,
  // any other reset source, synchronous, leaves the target address alone
  input wire logic soft_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // towards the erase and program sequencer
  output logic flash_start,
  output logic [3:0] flash_op,
  output logic [31:0] flash_addr,
  output logic flash_addr_used,
  output logic flash_busy,
  input wire logic flash_done
);
  import fu_pkg::*;

  localparam fu_regs_state_t REGS_RST = '{
    addr: `FU_ADDR_RST,
    op: FU_OP_NOP,
    busy: 1'b0,
    err: 1'b0,
    go: 1'b0,
    go_op: FU_OP_NOP,
    go_addr: `FU_ZERO_WORD,
    go_used: 1'b0,
    rdata: `FU_ZERO_WORD
  };

  fu_regs_state_t cur_ff;
  fu_regs_state_t nxt_ff;

  logic key_wr;
  logic addr_wr;
  logic ctl_wr;
  logic go_req;
  logic unlocked;
  logic [3:0] new_op;
  logic [31:0] ctl_rd;

  assign key_wr = reg_wr && (reg_addr == `FU_OFF_KEY) && !soft_rst;
  assign addr_wr = reg_wr && (reg_addr == `FU_OFF_ADDR) && !soft_rst;
  assign ctl_wr = reg_wr && (reg_addr == `FU_OFF_CTL) && !soft_rst;
  assign go_req = ctl_wr && reg_wdata[`FU_CTL_GO_BIT];
  assign new_op = reg_wdata[`FU_CTL_OP_MSB:`FU_CTL_OP_LSB];

  // key values never reach a register; they only walk the gate
  fu_keychk #(
    .KEY_FIRST(KEY_FIRST),
    .KEY_SECOND(KEY_SECOND)
  ) u_keychk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_rst(soft_rst),
    .key_wr(key_wr), // RULE2
    .key_data(reg_wdata),
    .consume(go_req),
    .unlocked(unlocked)
  );

  always_comb begin
    ctl_rd = `FU_ZERO_WORD;
    ctl_rd[`FU_CTL_OP_MSB:`FU_CTL_OP_LSB] = cur_ff.op;
    ctl_rd[`FU_CTL_BUSY_BIT] = cur_ff.busy;
    ctl_rd[`FU_CTL_UNLK_BIT] = unlocked;
    ctl_rd[`FU_CTL_ERR_BIT] = cur_ff.err;
  end

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.go = 1'b0;
    nxt_ff.rdata = `FU_ZERO_WORD;
    if (soft_rst) begin
      // soft resets clear control state but the target address survives
      nxt_ff = REGS_RST;
      nxt_ff.addr = cur_ff.addr; // RULE9
    end else begin
      if (reg_rd) begin
        if (reg_addr == `FU_OFF_KEY) begin
          nxt_ff.rdata = `FU_ZERO_WORD; // RULE1
        end else if (reg_addr == `FU_OFF_ADDR) begin
          nxt_ff.rdata = cur_ff.addr; // RULE3
        end else if (reg_addr == `FU_OFF_CTL) begin
          nxt_ff.rdata = ctl_rd;
        end else begin
          nxt_ff.rdata = `FU_ZERO_WORD;
        end
      end
      if (addr_wr) begin
        nxt_ff.addr = reg_wdata; // RULE3
      end
      if (cur_ff.busy && flash_done) begin
        nxt_ff.busy = 1'b0;
      end
      if (ctl_wr) begin
        nxt_ff.op = new_op;
        if (reg_wdata[`FU_CTL_ERR_BIT]) begin
          nxt_ff.err = 1'b0;
        end
      end
      if (go_req) begin
        // a done in the same cycle does not yet free the sequencer
        if (unlocked && !cur_ff.busy) begin
          nxt_ff.go = 1'b1; // RULE2
          nxt_ff.busy = 1'b1;
          nxt_ff.go_op = new_op;
          // low bits are dropped here so the sequencer never sees them
          nxt_ff.go_addr = cur_ff.addr & ~fu_ign_mask(new_op); // RULE4 RULE5 RULE6 RULE7 RULE8
          nxt_ff.go_used = fu_op_uses_addr(new_op); // RULE8
        end else begin
          // set after the clear, so a refused start is never lost
          nxt_ff.err = 1'b1; // RULE10
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= REGS_RST;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign reg_rdata = cur_ff.rdata;
  assign flash_start = cur_ff.go;
  assign flash_op = cur_ff.go_op;
  assign flash_addr = cur_ff.go_addr;
  assign flash_addr_used = cur_ff.go_used;
  assign flash_busy = cur_ff.busy;

  default clocking fu_cb @(posedge core_clk);
  endclocking

  default disable iff (!rst_n);

  key_read_zero_a: assert property ( // RULE1
    (reg_rd && reg_addr == `FU_OFF_KEY) |=> (reg_rdata == 32'h0000_0000))
    else $error("unlock key register read back non-zero");

  start_gated_a: assert property ( // RULE2
    flash_start |-> ($past(unlocked) && $past(go_req) && !$past(cur_ff.busy)))
    else $error("operation started without an open unlock gate");

  addr_readback_a: assert property ( // RULE3
    (addr_wr ##1 (reg_rd && reg_addr == `FU_OFF_ADDR && !soft_rst && !reg_wr))
    |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("target address did not read back as written");

  page_mask_a: assert property ( // RULE4
    (flash_start && flash_op == FU_OP_PAGE)
    |-> (flash_addr == ($past(cur_ff.addr) & 32'hffff_f000)) && flash_addr_used)
    else $error("page erase address not aligned to bit 12");

  row_mask_a: assert property ( // RULE5
    (flash_start && flash_op == FU_OP_ROW)
    |-> (flash_addr == ($past(cur_ff.addr) & 32'hffff_fe00)) && flash_addr_used)
    else $error("row program address not aligned to bit 9");

  word_mask_a: assert property ( // RULE6
    (flash_start && flash_op == FU_OP_WORD)
    |-> (flash_addr == ($past(cur_ff.addr) & 32'hffff_fffc)) && flash_addr_used)
    else $error("word program address not aligned to bit 2");

  quad_mask_a: assert property ( // RULE7
    (flash_start && flash_op == FU_OP_QUAD)
    |-> (flash_addr == ($past(cur_ff.addr) & 32'hffff_fff0)) && flash_addr_used)
    else $error("quad word program address not aligned to bit 4");

  other_op_a: assert property ( // RULE8
    (flash_start && flash_op != FU_OP_PAGE && flash_op != FU_OP_ROW &&
     flash_op != FU_OP_WORD && flash_op != FU_OP_QUAD)
    |-> (!flash_addr_used && flash_addr == 32'h0000_0000))
    else $error("address forwarded for an operation that has none");

  soft_keep_a: assert property ( // RULE9
    soft_rst |=> ($stable(cur_ff.addr) && !flash_busy && !flash_start))
    else $error("soft reset disturbed the target address or missed control state");

  bad_start_a: assert property ( // RULE10
    (go_req && !unlocked) |=> (!flash_start && cur_ff.err) ##1 !flash_start)
    else $error("start without unlock was not refused and flagged");

  cov_good_start_c: cover property (
    key_wr ##[1:4] key_wr ##[1:4] (go_req && unlocked) ##1 flash_start);

  cov_refused_c: cover property ((go_req && !unlocked) ##1 cur_ff.err);

  cov_page_c: cover property (flash_start && flash_op == FU_OP_PAGE);

  cov_done_c: cover property (flash_busy ##1 flash_done ##1 !flash_busy);

endmodule

// ===== dv/fu_regs_tb.sv
`timescale 1ns/100ps
`include "fu_cfg.svh"
module fu_regs_tb;
  import fu_pkg::*;
  localparam logic [31:0] K1 = `FU_KEY_FIRST_DFLT;
  localparam logic [31:0] K2 = `FU_KEY_SECOND_DFLT;
  localparam logic [31:0] ADR = 32'hfedc_bfff;
  logic core_clk, rst_n, soft_rst, reg_wr, reg_rd, flash_done;
  logic [3:0] reg_addr, flash_op;
  logic [31:0] reg_wdata, reg_rdata, flash_addr, rd_val, exp_a;
  logic flash_start, flash_addr_used, flash_busy;
  logic [3:0] op_list [6] = '{4'h4, 4'h3, 4'h1, 4'h2, 4'h0, 4'hf};
  int ign_list [6] = '{12, 9, 2, 4, 0, 0};
  logic [3:0] prev;
  int failures, checked;

  fu_regs #(.KEY_FIRST(K1), .KEY_SECOND(K2)) i_fu_regs (
    .core_clk(core_clk), .rst_n(rst_n), .soft_rst(soft_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_start(flash_start), .flash_op(flash_op),
    .flash_addr(flash_addr), .flash_addr_used(flash_addr_used),
    .flash_busy(flash_busy), .flash_done(flash_done)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  // strobe launched after one edge, taken at the next; outputs settle 1 ns later
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    chk_word(what, exp, rd_val);
  endtask

  // write then read back with no idle cycle between the strobes
  task automatic wr_rd(input string what, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    chk_word(what, exp, rd_val);
  endtask

  task automatic unlock();
    wr(`FU_OFF_KEY, K1);
    wr(`FU_OFF_KEY, K2);
  endtask

  task automatic done_pulse();
    @(posedge core_clk);
    flash_done <= 1'b1;
    @(posedge core_clk);
    flash_done <= 1'b0;
    #1;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard: the whole sequence needs far fewer cycles than this
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    soft_rst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    flash_done = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk("addr reset", `FU_OFF_ADDR, 32'h0000_0000);
    chk_bit("busy reset", 1'b0, flash_busy);
    wr_rd("addr rw", `FU_OFF_ADDR, 32'ha5c3_96f1, 32'ha5c3_96f1);
    wr_rd("key ones", `FU_OFF_KEY, 32'hffff_ffff, 32'h0000_0000);
    wr(`FU_OFF_KEY, K1);
    rd_chk("key first", `FU_OFF_KEY, 32'h0000_0000);
    rd_chk("unmapped", 4'hc, 32'h0000_0000);
    $display("test registers done");
    // one key step alone must not open the gate
    wr(`FU_OFF_CTL, 32'h0000_0084);
    chk_bit("start locked", 1'b0, flash_start);
    rd_chk("ctl err", `FU_OFF_CTL, 32'h0000_0044);
    wr(`FU_OFF_CTL, 32'h0000_0040);
    rd_chk("ctl clear", `FU_OFF_CTL, 32'h0000_0000);
    wr(`FU_OFF_KEY, K1);
    wr(`FU_OFF_KEY, 32'h0bad_0bad);
    wr(`FU_OFF_KEY, K2);
    wr(`FU_OFF_CTL, 32'h0000_0084);
    chk_bit("start bad key", 1'b0, flash_start);
    wr(`FU_OFF_CTL, 32'h0000_0040);
    $display("test refusal done");
    wr(`FU_OFF_ADDR, ADR);
    prev = 4'h0;
    for (int i = 0; i < 6; i++) begin
      unlock();
      rd_chk("ctl open", `FU_OFF_CTL, {26'h0, 2'b10, prev});
      wr(`FU_OFF_CTL, {24'h0, 4'h8, op_list[i]});
      exp_a = (ign_list[i] == 0) ? 32'h0 : ADR & ~((32'h1 << ign_list[i]) - 32'h1);
      chk_bit("start", 1'b1, flash_start);
      chk_word("op", {28'h0, op_list[i]}, {28'h0, flash_op});
      chk_word("addr", exp_a, flash_addr);
      chk_bit("used", ign_list[i] != 0, flash_addr_used);
      chk_bit("busy", 1'b1, flash_busy);
      done_pulse();
      chk_bit("idle", 1'b0, flash_busy);
      chk_bit("start pulse", 1'b0, flash_start);
      prev = op_list[i];
    end
    $display("test operations done");
    unlock();
    wr(`FU_OFF_CTL, 32'h0000_0081);
    chk_bit("start one", 1'b1, flash_start);
    unlock();
    wr(`FU_OFF_CTL, 32'h0000_0081);
    chk_bit("start busy", 1'b0, flash_start);
    rd_chk("ctl busy err", `FU_OFF_CTL, 32'h0000_0051);
    done_pulse();
    $display("test busy done");
    @(posedge core_clk);
    // a write beside the soft reset must be dropped, not land on the address
    soft_rst <= 1'b1;
    reg_addr <= `FU_OFF_ADDR;
    reg_wdata <= 32'h0000_0000;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    reg_wr <= 1'b0;
    rd_chk("addr kept", `FU_OFF_ADDR, ADR);
    @(posedge core_clk);
    #1;
    chk_word("rdata idle", 32'h0000_0000, reg_rdata);
    rd_chk("ctl soft", `FU_OFF_CTL, 32'h0000_0000);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk("addr por", `FU_OFF_ADDR, 32'h0000_0000);
    $display("test resets done");
    wrap_up();
  end
endmodule
